//--- dv/asp_serial_node.sv
// remote serial node model: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none

// ==========
// serial node
module asp_serial_node #(
   parameter int BIT_LEN = 16
) (
   input wire logic pclk,
   output logic rx_line,
   input wire logic tx_line
);
   // line idles high, as with a pull-up, whenever no frame is sent
   initial rx_line = 1'b1;

   // one bit; a one-cycle glitch near the centre must lose the vote
   task automatic drive_bit(input logic v, input bit g);
      for (int c = 0; c < BIT_LEN; c++)
      begin
         @(posedge pclk);
         rx_line <= (g && c == 7) ? ~v : v;
      end
   endtask : drive_bit

   // start, data lsb first, stop (low when bad), one idle bit
   task automatic send(input logic [8:0] d, input int nb, input bit bad, input bit g);
      drive_bit(1'b0, 1'b0);
      for (int i = 0; i < nb; i++)
         drive_bit(d[i], g);
      drive_bit(~bad, 1'b0);
      drive_bit(1'b1, 1'b0);
   endtask : send

   // short low pulse that is no valid start
   task automatic false_start(input int n);
      @(posedge pclk);
      rx_line <= 1'b0;
      repeat (n) @(posedge pclk);
      rx_line <= 1'b1;
      repeat (11 * BIT_LEN) @(posedge pclk);
   endtask : false_start

   // decode one frame at bit centres, lsb first
   task automatic recv(input int nb, output logic [8:0] d, output logic stop);
      d = '0;
      @(negedge tx_line);
      repeat (BIT_LEN / 2) @(posedge pclk);
      for (int i = 0; i < nb; i++)
      begin
         repeat (BIT_LEN) @(posedge pclk);
         d[i] = tx_line;
      end
      repeat (BIT_LEN) @(posedge pclk);
      stop = tx_line;
   endtask : recv
endmodule : asp_serial_node
`default_nettype wire

//--- dv/async_serial_tx_rx_port_tb_top.sv
// self-checking testbench of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

// ==========
// testbench top
module async_serial_tx_rx_port_tb_top;
   typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic err;} asp_row_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, tx_line, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [8:0] got;
   logic stp, e;
   int miscompares = 0;
   int n_checks = 0;
   asp_row_s rows [6];

   asp_port #(.DEPTH(2)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
   asp_serial_node #(.BIT_LEN(16)) node_u (.pclk(pclk), .rx_line(rx_line), .tx_line(tx_line));

   // 200 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; request held until pready seen, idle edge after release
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic y;
      apb(a, 1'b1, d, x, y);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] x;
      logic y;
      apb(a, 1'b0, 32'h0, x, y);
      chk(x, exp);
   endtask : rchk

   // hang guard, well beyond the expected run
   initial
   begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      end_sim();
   end

   // main sequence
   initial
   begin
      rows = '{'{`ASP_OFF_DIVLO, 32'h5a, 32'h5a, 1'b0}, '{`ASP_OFF_DIVHI, 32'h3c, 32'h3c, 1'b0},
               '{`ASP_OFF_BAUDCTL, 32'h18, 32'h18, 1'b0}, '{`ASP_OFF_TXDATA, 32'h77, 32'h0, 1'b0},
               '{`ASP_OFF_IRQCTL, 32'h30, 32'h0, 1'b0}, '{8'h20, 32'hff, 32'h0, 1'b1}};
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({31'h0, tx_line}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rchk(`ASP_OFF_RXSTAT, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         apb(rows[i].a, 1'b1, rows[i].wd, r, e);
         chk({31'h0, e}, {31'h0, rows[i].err});
         apb(rows[i].a, 1'b0, 32'h0, r, e);
         chk(r, rows[i].rd);
         chk({31'h0, e}, {31'h0, rows[i].err});
      end
      // inversion from the rows applies to the idle level as well
      chk({31'h0, tx_line}, 32'h0);
      wr(`ASP_OFF_DIVLO, 32'h0);
      wr(`ASP_OFF_DIVHI, 32'h0);
      wr(`ASP_OFF_BAUDCTL, 32'h0);
      $display("done: register rows");
      // transmit set-up and interrupt gating
      wr(`ASP_OFF_RXSTAT, 32'h90);
      rchk(`ASP_OFF_IRQCTL, 32'h0);
      wr(`ASP_OFF_TXSTAT, 32'h20);
      rchk(`ASP_OFF_IRQCTL, 32'h10);
      wr(`ASP_OFF_IRQCTL, 32'h0d);
      chk({31'h0, irq}, 32'h1);
      wr(`ASP_OFF_IRQCTL, 32'h05);
      chk({31'h0, irq}, 32'h0);
      wr(`ASP_OFF_IRQCTL, 32'h0);
      fork
         wr(`ASP_OFF_TXDATA, 32'ha5);
         node_u.recv(8, got, stp);
      join
      chk({23'h0, got}, 32'ha5);
      chk({31'h0, stp}, 32'h1);
      wr(`ASP_OFF_TXSTAT, 32'h61);
      fork
         wr(`ASP_OFF_TXDATA, 32'h02);
         node_u.recv(9, got, stp);
      join
      chk({23'h0, got}, 32'h102);
      // recv returns mid stop bit; let the shifter drain before reading idle
      repeat (16) @(posedge pclk);
      wr(`ASP_OFF_TXSTAT, 32'h20);
      rchk(`ASP_OFF_TXSTAT, 32'h22);
      $display("done: transmit");
      // reception with glitches, framing error, false start
      node_u.send(9'h3c, 8, 1'b0, 1'b1);
      rchk(`ASP_OFF_IRQCTL, 32'h30);
      rchk(`ASP_OFF_RXSTAT, 32'h90);
      rchk(`ASP_OFF_RXDATA, 32'h3c);
      rchk(`ASP_OFF_IRQCTL, 32'h10);
      node_u.send(9'h81, 8, 1'b1, 1'b0);
      rchk(`ASP_OFF_RXSTAT, 32'h94);
      rchk(`ASP_OFF_RXDATA, 32'h81);
      node_u.false_start(4);
      rchk(`ASP_OFF_IRQCTL, 32'h10);
      rchk(`ASP_OFF_RXSTAT, 32'h90);
      // nine-bit reception, ninth bit seen in the status of the head
      wr(`ASP_OFF_RXSTAT, 32'hd0);
      node_u.send(9'h1a5, 9, 1'b0, 1'b0);
      rchk(`ASP_OFF_RXSTAT, 32'hd1);
      rchk(`ASP_OFF_RXDATA, 32'ha5);
      wr(`ASP_OFF_RXSTAT, 32'h90);
      $display("done: receive");
      // fifo depth, overrun blocking and its clearing
      node_u.send(9'h11, 8, 1'b0, 1'b0);
      node_u.send(9'h22, 8, 1'b0, 1'b0);
      node_u.send(9'h33, 8, 1'b0, 1'b0);
      rchk(`ASP_OFF_RXSTAT, 32'h92);
      rchk(`ASP_OFF_RXDATA, 32'h11);
      node_u.send(9'h44, 8, 1'b0, 1'b0);
      rchk(`ASP_OFF_RXDATA, 32'h22);
      rchk(`ASP_OFF_RXDATA, 32'h0);
      wr(`ASP_OFF_RXSTAT, 32'h80);
      node_u.send(9'h66, 8, 1'b0, 1'b0);
      wr(`ASP_OFF_RXSTAT, 32'h90);
      rchk(`ASP_OFF_RXSTAT, 32'h90);
      rchk(`ASP_OFF_RXDATA, 32'h0);
      $display("done: overrun");
      // receive interrupt gating and port disable
      node_u.send(9'h55, 8, 1'b0, 1'b0);
      wr(`ASP_OFF_IRQCTL, 32'h0e);
      chk({31'h0, irq}, 32'h1);
      wr(`ASP_OFF_IRQCTL, 32'h0c);
      chk({31'h0, irq}, 32'h0);
      rchk(`ASP_OFF_IRQCTL, 32'h3c);
      wr(`ASP_OFF_RXSTAT, 32'h0);
      wr(`ASP_OFF_RXSTAT, 32'h90);
      rchk(`ASP_OFF_RXDATA, 32'h0);
      $display("done: interrupts and disable");
      end_sim();
   end
endmodule : async_serial_tx_rx_port_tb_top
`default_nettype wire

//--- hw/asp_defines.svh
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
// register byte offsets, one aligned word each
`define ASP_OFF_TXSTAT 8'h00
`define ASP_OFF_RXSTAT 8'h04
`define ASP_OFF_BAUDCTL 8'h08
`define ASP_OFF_DIVLO 8'h0c
`define ASP_OFF_DIVHI 8'h10
`define ASP_OFF_TXDATA 8'h14
`define ASP_OFF_RXDATA 8'h18
`define ASP_OFF_IRQCTL 8'h1c
// transmit_status_control fields
`define ASP_TX_NINE 6
`define ASP_TX_EN 5
`define ASP_TX_SYNC 4
`define ASP_TX_IDLE 1
`define ASP_TX_NINTH 0
// receive_status_control fields
`define ASP_RX_SERIAL_PORT_ENABLE 7
`define ASP_RX_NINE 6
`define ASP_RX_CONTINUOUS_RECEIVE_ENABLE 4
`define ASP_RX_FRAMING_ERROR_STATUS 2
`define ASP_RX_OVERRUN_ERROR_STATUS 1
`define ASP_RX_NINTH 0
// baud_control fields
`define ASP_BD_INV 4
`define ASP_BD_WIDE 3
// interrupt control fields
`define ASP_IE_TX 0
`define ASP_IE_RX 1
`define ASP_IE_PERI 2
`define ASP_IE_GLOB 3
`define ASP_IF_TX 4
`define ASP_IF_RX 5
// reset values
`define ASP_RST_BYTE 8'h00
`define ASP_RST_DIV 8'h00
// oversampling timing, in 16x ticks
`define ASP_OS_LAST 4'hf
`define ASP_OS_HALF 4'h7
// data and stop centres fall a whole 16 ticks after the start check
`define ASP_OS_MID 4'h7
`define ASP_BITS8 4'ha
`define ASP_BITS9 4'hb
`endif

//--- hw/asp_pkg.sv
// types shared by the serial port design
package asp_pkg;
   typedef enum logic [1:0] {
      ASP_RX_IDLE = 2'b00,
      ASP_RX_START = 2'b01,
      ASP_RX_DATA = 2'b10,
      ASP_RX_STOP = 2'b11
   } asp_rx_state_e;
   typedef logic [9:0] asp_entry_t; // {framing error, ninth bit, data}
endpackage : asp_pkg

//--- hw/asp_port.sv
// asynchronous serial port: apb registers, transmitter and oversampled receiver
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "asp_defines.svh"

// Notes on behaviour
// - in nine-bit mode a set ninth bit marks the byte as address
// - setting transmit enable asserts the transmit buffer empty flag
// - transmit interrupt fires while flag set and all three enables set
// - ninth bit loaded first; writing transmit data starts transmission
// - receive line sampled at sixteen times baud, shifter advances per bit
// - complete character moves at once into a two-entry fifo
// - fifo and shift register hidden; data only via receive data register
// - receiver runs only with receive enable, sync clear, port enable
// - start checked low at half bit, else silently dropped, resume watch
// - each data bit taken at centre by majority, shifted in
// - stop sampled one bit later; low sets framing error, high clears
// - after stop the character is pushed and pending flag set
// - reading receive data returns oldest character and removes it
// - while overrun stands no further characters are accepted
// - pending flag equals enabled and fifo not empty; software cannot touch
// - receive interrupt needs all three enables; flag ignores enables
// - frame is low start, eight or nine data bits, high stop, idle high
// - least significant bit first both ways, same rate; inversion acts on the transmit line only
// - buffer empty flag set when enabled and nothing waits; read-only
module asp_port #(
   parameter int DEPTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   output logic tx_line,
   output logic irq
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   function automatic logic majority(input logic a, input logic b, input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction : majority

   // ==========================================================
   // apb decode
   logic wr_en;
   logic rd_en;
   logic hit;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign hit = (paddr == `ASP_OFF_TXSTAT) | (paddr == `ASP_OFF_RXSTAT) |
                (paddr == `ASP_OFF_BAUDCTL) | (paddr == `ASP_OFF_DIVLO) |
                (paddr == `ASP_OFF_DIVHI) | (paddr == `ASP_OFF_TXDATA) |
                (paddr == `ASP_OFF_RXDATA) | (paddr == `ASP_OFF_IRQCTL);
   assign pready = 1'b1; // every access completes in its first access cycle
   assign pslverr = psel & penable & ~hit;

   // ==========================================================
   // control registers
   logic [7:0] txctl_r;
   logic [7:0] rxctl_r;
   logic [7:0] baud_r;
   logic [7:0] divlo_r;
   logic [7:0] divhi_r;
   logic [3:0] ie_r;
   logic serial_port_enable;
   logic tx_on;
   logic rx_on;
   assign serial_port_enable = rxctl_r[`ASP_RX_SERIAL_PORT_ENABLE];
   assign tx_on = txctl_r[`ASP_TX_EN] & ~txctl_r[`ASP_TX_SYNC] & serial_port_enable;
   assign rx_on = rxctl_r[`ASP_RX_CONTINUOUS_RECEIVE_ENABLE] & ~txctl_r[`ASP_TX_SYNC] & serial_port_enable;

   // software-writable fields only; status bits are never stored here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         txctl_r <= `ASP_RST_BYTE;
         rxctl_r <= `ASP_RST_BYTE;
         baud_r <= `ASP_RST_BYTE;
         divlo_r <= `ASP_RST_DIV;
         divhi_r <= `ASP_RST_DIV;
         ie_r <= 4'h0;
      end
      else if (wr_en)
      begin
         if (paddr == `ASP_OFF_TXSTAT) txctl_r <= pwdata[7:0] & 8'h71;
         if (paddr == `ASP_OFF_RXSTAT) rxctl_r <= pwdata[7:0] & 8'hd0;
         if (paddr == `ASP_OFF_BAUDCTL) baud_r <= pwdata[7:0] & 8'h18;
         if (paddr == `ASP_OFF_DIVLO) divlo_r <= pwdata[7:0];
         if (paddr == `ASP_OFF_DIVHI) divhi_r <= pwdata[7:0];
         if (paddr == `ASP_OFF_IRQCTL) ie_r <= pwdata[3:0];
      end
   end

   // ==========================================================
   // 16x oversampling tick, shared by both directions
   logic [15:0] div;
   logic [15:0] os_cnt_r;
   logic tick;
   assign div = baud_r[`ASP_BD_WIDE] ? {divhi_r, divlo_r} : {8'h00, divlo_r};
   assign tick = serial_port_enable & (os_cnt_r >= div);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) os_cnt_r <= 16'h0000;
      else if (!serial_port_enable || tick) os_cnt_r <= 16'h0000;
      else os_cnt_r <= os_cnt_r + 16'h0001;
   end

   // ==========================================================
   // transmitter: one-character buffer feeding the shift register
   logic tx_wr;
   logic [8:0] tbuf_r;
   logic tbuf_full_r;
   logic [10:0] tsr_r;
   logic [3:0] tbits_r;
   logic [3:0] tcnt_r;
   logic tbusy_r;
   logic tload;
   logic tbit_end;
   logic transmit_buffer_empty_flag;
   assign tx_wr = wr_en & (paddr == `ASP_OFF_TXDATA) & tx_on;
   assign tload = tx_on & tbuf_full_r & ~tbusy_r;
   assign tbit_end = tick & (tcnt_r == `ASP_OS_LAST);
   assign transmit_buffer_empty_flag = tx_on & ~tbuf_full_r;

   // ninth bit is captured with the byte, so it must be set up first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tbuf_r <= 9'h000;
         tbuf_full_r <= 1'b0;
      end
      else if (!tx_on) tbuf_full_r <= 1'b0;
      else if (tx_wr)
      begin
         tbuf_r <= {txctl_r[`ASP_TX_NINTH], pwdata[7:0]};
         tbuf_full_r <= 1'b1;
      end
      else if (tload) tbuf_full_r <= 1'b0;
   end

   // frame: start low, data lsb first, optional ninth, stop high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tsr_r <= 11'h7ff;
         tbits_r <= 4'h0;
         tcnt_r <= 4'h0;
         tbusy_r <= 1'b0;
      end
      else if (!tx_on)
      begin
         tsr_r <= 11'h7ff;
         tbusy_r <= 1'b0;
      end
      else if (tload)
      begin
         tsr_r <= {1'b1, txctl_r[`ASP_TX_NINE] ? tbuf_r[8] : 1'b1,
                   tbuf_r[7:0], 1'b0};
         tbits_r <= txctl_r[`ASP_TX_NINE] ? `ASP_BITS9 : `ASP_BITS8;
         tcnt_r <= 4'h0;
         tbusy_r <= 1'b1;
      end
      else if (tbusy_r && tick)
      begin
         tcnt_r <= tcnt_r + 4'h1;
         if (tbit_end)
         begin
            tsr_r <= {1'b1, tsr_r[10:1]};
            tbits_r <= tbits_r - 4'h1;
            if (tbits_r == 4'h1) tbusy_r <= 1'b0;
         end
      end
   end

   logic tx_raw;
   assign tx_raw = tbusy_r ? tsr_r[0] : 1'b1; // idle mark
   // inversion applies to idle too, as the far end expects a steady level
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) tx_line <= 1'b1;
      else tx_line <= tx_raw ^ baud_r[`ASP_BD_INV];
   end

   // ==========================================================
   // receiver state machine
   asp_pkg::asp_rx_state_e rst_r;
   asp_pkg::asp_rx_state_e rst_nxt;
   logic rx_prev_r;
   logic [3:0] rcnt_r;
   logic [3:0] rbits_r;
   logic [8:0] rsr_r;
   logic [1:0] smp_r;
   logic vote;
   logic at_mid;
   logic at_half;
   logic fall;
   logic overrun_error_status_r;
   logic push;
   logic full;
   logic [CW-1:0] cnt_r;
   assign vote = majority(smp_r[1], smp_r[0], rx_line);
   assign at_mid = tick & (rcnt_r == `ASP_OS_MID);
   assign at_half = tick & (rcnt_r == `ASP_OS_HALF);
   assign fall = rx_prev_r & ~rx_line;
   assign full = (cnt_r == CW'(DEPTH));

   // a standing overrun parks the receiver in idle
   always_comb
   begin
      rst_nxt = rst_r;
      unique case (rst_r)
         asp_pkg::ASP_RX_IDLE:
            if (fall && !overrun_error_status_r) rst_nxt = asp_pkg::ASP_RX_START;
         asp_pkg::ASP_RX_START:
            if (at_half) rst_nxt = rx_line ? asp_pkg::ASP_RX_IDLE
                                           : asp_pkg::ASP_RX_DATA;
         asp_pkg::ASP_RX_DATA:
            if (at_mid && rbits_r == 4'h1) rst_nxt = asp_pkg::ASP_RX_STOP;
         asp_pkg::ASP_RX_STOP:
            if (at_mid) rst_nxt = asp_pkg::ASP_RX_IDLE;
      endcase
      if (!rx_on) rst_nxt = asp_pkg::ASP_RX_IDLE;
   end

   // tick counter restarts at the edge, so count 7 is mid start bit
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_r <= asp_pkg::ASP_RX_IDLE;
         rx_prev_r <= 1'b1;
         rcnt_r <= 4'h0;
         smp_r <= 2'b11;
      end
      else
      begin
         rst_r <= rst_nxt;
         rx_prev_r <= rx_line;
         if (rst_r == asp_pkg::ASP_RX_IDLE) rcnt_r <= 4'h0;
         else if (tick) rcnt_r <= rcnt_r + 4'h1;
         if (tick) smp_r <= {smp_r[0], rx_line};
      end
   end

   // data bits shift in lsb first from the top
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rsr_r <= 9'h000;
         rbits_r <= 4'h0;
      end
      else if (rst_r == asp_pkg::ASP_RX_START)
         rbits_r <= rxctl_r[`ASP_RX_NINE] ? 4'h9 : 4'h8;
      else if (rst_r == asp_pkg::ASP_RX_DATA && at_mid)
      begin
         rsr_r <= {vote, rsr_r[8:1]};
         rbits_r <= rbits_r - 4'h1;
      end
   end

   // ==========================================================
   // receive fifo; data reachable only through the receive data register, head flags also read in receive status
   asp_pkg::asp_entry_t mem_r [DEPTH];
   asp_pkg::asp_entry_t head;
   asp_pkg::asp_entry_t entry;
   logic [PW-1:0] wp_r;
   logic [PW-1:0] rp_r;
   logic pop;
   logic stop_done;
   assign stop_done = (rst_r == asp_pkg::ASP_RX_STOP) & at_mid & rx_on;
   assign push = stop_done & ~full & ~overrun_error_status_r;
   assign pop = rd_en & (paddr == `ASP_OFF_RXDATA) & (cnt_r != '0);
   assign entry = rxctl_r[`ASP_RX_NINE] ? {~vote, rsr_r}
                                        : {~vote, 1'b0, rsr_r[8:1]};
   assign head = mem_r[rp_r];

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : ptr_inc

   always_ff @(posedge pclk)
   begin
      if (push) mem_r[wp_r] <= entry;
   end

   // port disable empties the fifo; receive enable alone does not
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else if (!serial_port_enable)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push) wp_r <= ptr_inc(wp_r);
         if (pop) rp_r <= ptr_inc(rp_r);
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end

   // overrun: third whole character with the fifo full
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) overrun_error_status_r <= 1'b0;
      else if (!rx_on) overrun_error_status_r <= 1'b0;
      else if (stop_done && full) overrun_error_status_r <= 1'b1;
   end

   // ==========================================================
   // flags, interrupt and read mux
   logic receive_pending_flag;
   logic has_data;
   logic int_ok;
   assign has_data = (cnt_r != '0);
   assign receive_pending_flag = rx_on & has_data;
   assign int_ok = ie_r[`ASP_IE_GLOB] & ie_r[`ASP_IE_PERI];
   assign irq = int_ok & ((ie_r[`ASP_IE_TX] & transmit_buffer_empty_flag) |
                          (ie_r[`ASP_IE_RX] & receive_pending_flag));

   logic [7:0] rd_byte;
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (paddr)
         `ASP_OFF_TXSTAT: rd_byte = txctl_r | {6'h00, ~tbusy_r, 1'b0};
         `ASP_OFF_RXSTAT: rd_byte = rxctl_r | {5'h00, has_data & head[9],
                                                overrun_error_status_r, has_data & head[8]};
         `ASP_OFF_BAUDCTL: rd_byte = baud_r;
         `ASP_OFF_DIVLO: rd_byte = divlo_r;
         `ASP_OFF_DIVHI: rd_byte = divhi_r;
         `ASP_OFF_RXDATA: rd_byte = has_data ? head[7:0] : 8'h00;
         `ASP_OFF_IRQCTL: rd_byte = {2'b00, receive_pending_flag, transmit_buffer_empty_flag, ie_r};
         default: rd_byte = 8'h00;
      endcase
   end
   assign prdata = {24'h000000, rd_byte};

   // ==========================================================
   // checks
   sequence s_frame_start;
      (tx_raw == 1'b0) [*8];
   endsequence

   a_transmit_enable_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && paddr == `ASP_OFF_TXSTAT && pwdata[`ASP_TX_EN] && !pwdata[`ASP_TX_SYNC]
      && serial_port_enable && !tbuf_full_r |=> transmit_buffer_empty_flag)
      else $error("buffer empty flag missing after transmit enable");
   a_tx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      irq && !receive_pending_flag |-> transmit_buffer_empty_flag && ie_r == (ie_r | 4'hd))
      else $error("transmit interrupt without its enables");
   a_rx_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      irq && !transmit_buffer_empty_flag |-> rx_on && has_data && ie_r[`ASP_IE_RX] && int_ok)
      else $error("receive interrupt without its enables");
   a_start_low: assert property (@(posedge pclk) disable iff (!presetn)
      tload && div == 16'h0000 |=> s_frame_start)
      else $error("start bit not held low");
   a_false_start: assert property (@(posedge pclk) disable iff (!presetn)
      rst_r == asp_pkg::ASP_RX_START && at_half && rx_line && rx_on
      |=> rst_r == asp_pkg::ASP_RX_IDLE && cnt_r == $past(cnt_r) && !overrun_error_status_r)
      else $error("false start not dropped silently");
   a_push_count: assert property (@(posedge pclk) disable iff (!presetn)
      push && !pop |=> cnt_r == $past(cnt_r) + CW'(1) && receive_pending_flag)
      else $error("character not pushed after stop");
   a_pop_count: assert property (@(posedge pclk) disable iff (!presetn)
      pop && !push && serial_port_enable |=> cnt_r == $past(cnt_r) - CW'(1))
      else $error("read did not remove a character");
   a_overrun_block: assert property (@(posedge pclk) disable iff (!presetn)
      overrun_error_status_r |-> !push && rst_r != asp_pkg::ASP_RX_START)
      else $error("character accepted during overrun");
   a_serial_port_enable_reset: assert property (@(posedge pclk) disable iff (!presetn)
      !serial_port_enable |=> cnt_r == '0 && rst_r == asp_pkg::ASP_RX_IDLE && !overrun_error_status_r)
      else $error("port disable did not reset receiver");
   a_rx_gated: assert property (@(posedge pclk) disable iff (!presetn)
      rst_r != asp_pkg::ASP_RX_IDLE |-> $past(rx_on))
      else $error("receiver active while disabled");
endmodule : asp_port
`default_nettype wire
